// ---- rtl/lmc_pkg.sv ----
// Constants, register map and carrier types of the link membership control block.
// Assumes a single 200 MHz clock and an APB slave port with 32-bit data.
package lmc_pkg;

  localparam int NCH = 8;
  localparam int ADDR_W = 20;
  localparam int SEQ_THRESH = 3;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_POLICY = 20'h30a03;
  localparam logic [ADDR_W-1:0] IDX_RESYNC = 20'h30a04;
  localparam logic [ADDR_W-1:0] IDX_CELL_MODE = 20'h30a05;
  localparam logic [ADDR_W-1:0] IDX_ALIGN_CFG = 20'h30a10;
  localparam logic [ADDR_W-1:0] IDX_LINK_STAT = 20'h30a11;

  localparam logic [ADDR_W-1:0] ADDR_POLICY = {IDX_POLICY[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RESYNC = {IDX_RESYNC[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CELL_MODE = {IDX_CELL_MODE[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ALIGN_CFG = {IDX_ALIGN_CFG[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LINK_STAT = {IDX_LINK_STAT[ADDR_W-3:0], 2'b00};

  // Link group policy fields
  localparam int POL_TX_SUPPRESS = 0;
  localparam int POL_AUTO_BUNDLE = 1;
  localparam int POL_REJOIN_A = 3;
  localparam int POL_AUTO_REMOVE_A = 4;
  localparam int POL_REJOIN_B = 6;
  localparam int POL_AUTO_REMOVE_B = 7;
  localparam logic [7:0] POL_MASK = 8'hdb;

  // Alignment resync command fields
  localparam int RSY_QUAD_B = 1;
  localparam int RSY_PAIR_B_UPPER = 2;
  localparam int RSY_PAIR_B_LOWER = 3;
  localparam int RSY_QUAD_A = 4;
  localparam int RSY_PAIR_A_UPPER = 5;
  localparam int RSY_PAIR_A_LOWER = 6;
  localparam int RSY_OCTAL = 7;
  localparam logic [7:0] RSY_MASK = 8'hfe;

  // Cell mode enable fields
  localparam int CM_PAIR_A_LOWER = 3;
  localparam int CM_PAIR_A_UPPER = 4;
  localparam int CM_PAIR_B_LOWER = 5;
  localparam int CM_PAIR_B_UPPER = 6;
  localparam int CM_ALL = 7;
  localparam logic [7:0] CM_MASK = 8'hf8;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Channel masks: AA..AD are 0..3, BA..BD are 4..7
  localparam logic [7:0] CH_A_LOWER = 8'h03;
  localparam logic [7:0] CH_A_UPPER = 8'h0c;
  localparam logic [7:0] CH_B_LOWER = 8'h30;
  localparam logic [7:0] CH_B_UPPER = 8'hc0;
  localparam logic [7:0] CH_ALL = 8'hff;

  typedef struct packed {
    logic frame_lock;
    logic frame_boundary;
    logic seq_ok;
    logic seq_err;
  } lmc_link_ev_t;

  typedef enum logic [1:0] {
    LK_DOWN = 2'b01,
    LK_UP = 2'b10
  } lmc_link_state_t;

endpackage

// ---- rtl/lmc_link_tracker.sv ----
// Health tracker for one receive link: acquisition, removal and rejoin.
// Assumes frame_lock is a level and the other event inputs are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module lmc_link_tracker
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire lmc_pkg::lmc_link_ev_t ev_i,
  input wire logic rejoin_en_i,
  input wire logic auto_remove_en_i,
  output logic healthy_o,
  output logic seq_removed_o
);

  lmc_pkg::lmc_link_state_t state_r, state_nxt;
  logic [1:0] ok_cnt_r, ok_cnt_nxt;
  logic [1:0] err_cnt_r, err_cnt_nxt;
  logic removed_r, removed_nxt;

  localparam logic [1:0] LAST = 2'(lmc_pkg::SEQ_THRESH - 1);

  always_comb
  begin
    state_nxt = state_r;
    ok_cnt_nxt = ok_cnt_r;
    err_cnt_nxt = err_cnt_r;
    removed_nxt = removed_r;
    // Count consecutive correct sequence numbers
    if (ev_i.seq_err)
      ok_cnt_nxt = 2'h0;
    else if (ev_i.seq_ok && ok_cnt_r != LAST)
      ok_cnt_nxt = ok_cnt_r + 2'h1;
    unique case (state_r)
      lmc_pkg::LK_DOWN:
      begin
        if (!ev_i.frame_lock)
          removed_nxt = 1'b0;
        if (removed_r && rejoin_en_i && ev_i.seq_ok && !ev_i.seq_err && ok_cnt_r == LAST)
        begin
          state_nxt = lmc_pkg::LK_UP;
          removed_nxt = 1'b0;
          err_cnt_nxt = 2'h0;
        end
        else if (!removed_r && ev_i.frame_lock && ev_i.frame_boundary)
        begin
          state_nxt = lmc_pkg::LK_UP;
          err_cnt_nxt = 2'h0;
        end
      end
      lmc_pkg::LK_UP:
      begin
        if (!ev_i.frame_lock)
          state_nxt = lmc_pkg::LK_DOWN;
        else if (auto_remove_en_i && ev_i.seq_err)
        begin
          if (err_cnt_r == LAST)
          begin
            state_nxt = lmc_pkg::LK_DOWN;
            removed_nxt = 1'b1;
            err_cnt_nxt = 2'h0;
            ok_cnt_nxt = 2'h0;
          end
          else
            err_cnt_nxt = err_cnt_r + 2'h1;
        end
      end
      default:
      begin
        state_nxt = lmc_pkg::LK_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r <= lmc_pkg::LK_DOWN;
      ok_cnt_r <= 2'h0;
      err_cnt_r <= 2'h0;
      removed_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ok_cnt_r <= ok_cnt_nxt;
      err_cnt_r <= err_cnt_nxt;
      removed_r <= removed_nxt;
    end
  end

  assign healthy_o = (state_r == lmc_pkg::LK_UP);
  assign seq_removed_o = removed_r;

endmodule
`default_nettype wire

// ---- rtl/lmc_link_membership_control.sv ----
// Link membership control: group policy and alignment resync registers over APB.
// Assumes one 200 MHz clock, synchronous link events and an APB master.
//
// Summary of operation
// - Suppress set: no transmit on sequence-removed links
// - Suppress clear: transmit continues despite sequence errors
// - Auto bundling: healthy links keep delivering cells
// - No bundling: cells read only when group healthy
// - Rejoin: three correct sequences reassert link health
// - Auto remove: three sequence errors drop link health
// - Quad resync edge realigns that block's channels
// - Block B pair resync edges realign pairs
// - Block A pair resync edges realign pairs
// - Octal resync realigns all aligned channels
// - Resync acts on rising edge only
// - Health rises at frame boundary or on rejoin, drops anytime
// - Per-pair cell mode, all-links mode overrides
`timescale 1ns/1ps
`default_nettype none
module lmc_link_membership_control
#(
  parameter int NCH = lmc_pkg::NCH
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lmc_pkg::lmc_link_ev_t [NCH-1:0] link_ev_i,
  input wire logic [NCH-1:0] cell_avail_i,
  output logic [NCH-1:0] rx_link_healthy_o,
  output logic [NCH-1:0] tx_enable_o,
  output logic [NCH-1:0] cell_read_en_o,
  output logic [NCH-1:0] realign_o,
  output logic [NCH-1:0] cell_mode_o
);

  logic [7:0] policy_r, policy_nxt;
  logic [7:0] resync_r, resync_nxt;
  logic [7:0] resync_prev_r, resync_prev_nxt;
  logic [7:0] cell_mode_reg_r, cell_mode_reg_nxt;
  logic [7:0] align_cfg_r, align_cfg_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [NCH-1:0] healthy_r, healthy_nxt;
  logic [NCH-1:0] tx_en_r, tx_en_nxt;
  logic [NCH-1:0] cell_rd_r, cell_rd_nxt;
  logic [NCH-1:0] realign_r, realign_nxt;
  logic [NCH-1:0] cell_mode_r, cell_mode_nxt;
  logic [NCH-1:0] trk_healthy;
  logic [NCH-1:0] trk_removed;
  logic [NCH-1:0] rejoin_en;
  logic [NCH-1:0] remove_en;
  logic wr_take;
  logic [7:0] wbyte;

  // True for any mapped register address
  function automatic logic addr_hit(input logic [lmc_pkg::ADDR_W-1:0] a);
    addr_hit = (a == lmc_pkg::ADDR_POLICY) || (a == lmc_pkg::ADDR_RESYNC) ||
               (a == lmc_pkg::ADDR_CELL_MODE) || (a == lmc_pkg::ADDR_ALIGN_CFG) ||
               (a == lmc_pkg::ADDR_LINK_STAT);
  endfunction

  // Byte-lane merge of a writable register
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
    merge = pstrb[0] ? (wbyte & mask) : old;
  endfunction

  // True when every link selected by grp is healthy
  function automatic logic grp_good(input logic [NCH-1:0] h, input logic [7:0] grp);
    grp_good = ((h & grp) == grp);
  endfunction

  // Channels picked by the rising resync command bits
  function automatic logic [7:0] resync_sel(input logic [7:0] rise);
    resync_sel = 8'h00;
    if (rise[lmc_pkg::RSY_QUAD_B])
      resync_sel = resync_sel | lmc_pkg::CH_B_LOWER | lmc_pkg::CH_B_UPPER;
    if (rise[lmc_pkg::RSY_QUAD_A])
      resync_sel = resync_sel | lmc_pkg::CH_A_LOWER | lmc_pkg::CH_A_UPPER;
    if (rise[lmc_pkg::RSY_PAIR_B_UPPER])
      resync_sel = resync_sel | lmc_pkg::CH_B_UPPER;
    if (rise[lmc_pkg::RSY_PAIR_B_LOWER])
      resync_sel = resync_sel | lmc_pkg::CH_B_LOWER;
    if (rise[lmc_pkg::RSY_PAIR_A_UPPER])
      resync_sel = resync_sel | lmc_pkg::CH_A_UPPER;
    if (rise[lmc_pkg::RSY_PAIR_A_LOWER])
      resync_sel = resync_sel | lmc_pkg::CH_A_LOWER;
    if (rise[lmc_pkg::RSY_OCTAL])
      resync_sel = lmc_pkg::CH_ALL;
  endfunction

  // Channels of every pair enabled for cell mode
  function automatic logic [7:0] pair_mask(input logic [7:0] cm);
    pair_mask = 8'h00;
    if (cm[lmc_pkg::CM_PAIR_A_LOWER])
      pair_mask = pair_mask | lmc_pkg::CH_A_LOWER;
    if (cm[lmc_pkg::CM_PAIR_A_UPPER])
      pair_mask = pair_mask | lmc_pkg::CH_A_UPPER;
    if (cm[lmc_pkg::CM_PAIR_B_LOWER])
      pair_mask = pair_mask | lmc_pkg::CH_B_LOWER;
    if (cm[lmc_pkg::CM_PAIR_B_UPPER])
      pair_mask = pair_mask | lmc_pkg::CH_B_UPPER;
  endfunction

  // Link group of a channel: its pair, or all links in all-links cell mode
  function automatic logic [7:0] group_of(input int ch, input logic all);
    if (all)
      group_of = lmc_pkg::CH_ALL;
    else if (ch < 2)
      group_of = lmc_pkg::CH_A_LOWER;
    else if (ch < 4)
      group_of = lmc_pkg::CH_A_UPPER;
    else if (ch < 6)
      group_of = lmc_pkg::CH_B_LOWER;
    else
      group_of = lmc_pkg::CH_B_UPPER;
  endfunction

  // Per-link policy enables by block
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (i < NCH / 2)
      begin
        rejoin_en[i] = policy_r[lmc_pkg::POL_REJOIN_A];
        remove_en[i] = policy_r[lmc_pkg::POL_AUTO_REMOVE_A];
      end
      else
      begin
        rejoin_en[i] = policy_r[lmc_pkg::POL_REJOIN_B];
        remove_en[i] = policy_r[lmc_pkg::POL_AUTO_REMOVE_B];
      end
    end
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_link
    lmc_link_tracker u_trk
    (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ev_i(link_ev_i[g]),
      .rejoin_en_i(rejoin_en[g]),
      .auto_remove_en_i(remove_en[g]),
      .healthy_o(trk_healthy[g]),
      .seq_removed_o(trk_removed[g])
    );
  end

  // APB register access
  assign wr_take = psel && penable && pready_r && pwrite;
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    policy_nxt = policy_r;
    resync_nxt = resync_r;
    cell_mode_reg_nxt = cell_mode_reg_r;
    align_cfg_nxt = align_cfg_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = 1'b0;
    if (psel && !penable)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = !addr_hit(paddr);
      prdata_nxt = 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (1'b1)
          paddr == lmc_pkg::ADDR_POLICY: prdata_nxt = {24'h00_0000, policy_r};
          paddr == lmc_pkg::ADDR_RESYNC: prdata_nxt = {24'h00_0000, resync_r};
          paddr == lmc_pkg::ADDR_CELL_MODE: prdata_nxt = {24'h00_0000, cell_mode_reg_r};
          paddr == lmc_pkg::ADDR_ALIGN_CFG: prdata_nxt = {24'h00_0000, align_cfg_r};
          paddr == lmc_pkg::ADDR_LINK_STAT: prdata_nxt = {16'h0000, trk_removed, trk_healthy};
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (wr_take)
    begin
      unique case (1'b1)
        paddr == lmc_pkg::ADDR_POLICY:
          policy_nxt = merge(policy_r, lmc_pkg::POL_MASK);
        paddr == lmc_pkg::ADDR_RESYNC:
          resync_nxt = merge(resync_r, lmc_pkg::RSY_MASK);
        paddr == lmc_pkg::ADDR_CELL_MODE:
          cell_mode_reg_nxt = merge(cell_mode_reg_r, lmc_pkg::CM_MASK);
        paddr == lmc_pkg::ADDR_ALIGN_CFG:
          align_cfg_nxt = merge(align_cfg_r, 8'hff);
        default:
          policy_nxt = policy_r;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      policy_r <= lmc_pkg::REG_RESET;
      resync_r <= lmc_pkg::REG_RESET;
      cell_mode_reg_r <= lmc_pkg::REG_RESET;
      align_cfg_r <= lmc_pkg::REG_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      policy_r <= policy_nxt;
      resync_r <= resync_nxt;
      cell_mode_reg_r <= cell_mode_reg_nxt;
      align_cfg_r <= align_cfg_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Resync command edge detection
  always_comb
  begin
    logic [7:0] rise;
    logic [7:0] sel;
    rise = resync_r & ~resync_prev_r;
    sel = resync_sel(rise);
    resync_prev_nxt = resync_r;
    realign_nxt = sel[NCH-1:0] & align_cfg_r[NCH-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      resync_prev_r <= lmc_pkg::REG_RESET;
      realign_r <= '0;
    end
    else
    begin
      resync_prev_r <= resync_prev_nxt;
      realign_r <= realign_nxt;
    end
  end

  // Link-facing outputs
  always_comb
  begin
    logic [7:0] grp;
    grp = 8'h00;
    if (cell_mode_reg_r[lmc_pkg::CM_ALL])
      cell_mode_nxt = lmc_pkg::CH_ALL[NCH-1:0];
    else
      cell_mode_nxt = pair_mask(cell_mode_reg_r);
    healthy_nxt = trk_healthy;
    for (int i = 0; i < NCH; i++)
    begin
      // Suppress only links removed for sequence errors
      tx_en_nxt[i] = !(policy_r[lmc_pkg::POL_TX_SUPPRESS] && trk_removed[i]);
      grp = group_of(i, cell_mode_reg_r[lmc_pkg::CM_ALL]);
      if (policy_r[lmc_pkg::POL_AUTO_BUNDLE])
        cell_rd_nxt[i] = cell_mode_nxt[i] && trk_healthy[i] && cell_avail_i[i];
      else
        cell_rd_nxt[i] = cell_mode_nxt[i] && grp_good(trk_healthy, grp) && cell_avail_i[i];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cell_mode_r <= '0;
      healthy_r <= '0;
      tx_en_r <= '0;
      cell_rd_r <= '0;
    end
    else
    begin
      cell_mode_r <= cell_mode_nxt;
      healthy_r <= healthy_nxt;
      tx_en_r <= tx_en_nxt;
      cell_rd_r <= cell_rd_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rx_link_healthy_o = healthy_r;
  assign tx_enable_o = tx_en_r;
  assign cell_read_en_o = cell_rd_r;
  assign realign_o = realign_r;
  assign cell_mode_o = cell_mode_r;

endmodule
`default_nettype wire

// ---- testbench/lmc_asserts.sv ----
// Checker for the link membership control block, bound to its top module.
// Assumes APB writes commit at the pready edge with pstrb[0] set.
`timescale 1ns/1ps
`default_nettype none
module lmc_asserts
#(
  parameter int NCH = 8
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire lmc_pkg::lmc_link_ev_t [NCH-1:0] link_ev_i,
  input wire logic [NCH-1:0] rx_link_healthy_o,
  input wire logic [NCH-1:0] tx_enable_o,
  input wire logic [NCH-1:0] realign_o,
  input wire logic [NCH-1:0] cell_mode_o
);
  logic wr;
  logic [7:0] pol_r;
  logic [7:0] algn_r;
  logic [7:0] cm_r;
  logic [7:0] cmx;
  logic [NCH-1:0] fl;
  logic [NCH-1:0] fb;
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      fl[i] = link_ev_i[i].frame_lock;
      fb[i] = link_ev_i[i].frame_boundary;
    end
    cmx = cm_r[7] ? 8'hff : ({8{cm_r[3]}} & 8'h03) | ({8{cm_r[4]}} & 8'h0c) |
      ({8{cm_r[5]}} & 8'h30) | ({8{cm_r[6]}} & 8'hc0);
  end
  // Shadow copies of the written registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pol_r <= 8'h00;
      algn_r <= 8'h00;
      cm_r <= 8'h00;
    end
    else if (wr)
    begin
      if (paddr == lmc_pkg::ADDR_POLICY) pol_r <= pwdata[7:0] & lmc_pkg::POL_MASK;
      if (paddr == lmc_pkg::ADDR_ALIGN_CFG) algn_r <= pwdata[7:0];
      if (paddr == lmc_pkg::ADDR_CELL_MODE) cm_r <= pwdata[7:0] & lmc_pkg::CM_MASK;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready && $past(psel && !penable))
    else $error("error outside access");
  a_tx_free: assert property ((!srst_i && !pol_r[0]) [*2] |-> &tx_enable_o)
    else $error("transmit held while suppress clear");
  a_realign_once: assert property (|realign_o |=> (realign_o & $past(realign_o)) == '0)
    else $error("realign longer than one cycle");
  a_realign_mask: assert property ((realign_o & ~algn_r) == '0)
    else $error("realign on unaligned channel");
  a_realign_cause: assert property (|realign_o |-> $past(wr && paddr == lmc_pkg::ADDR_RESYNC, 2))
    else $error("realign without resync write");
  a_health_rise: assert property (!pol_r[3] && !pol_r[6] |->
    (rx_link_healthy_o & ~$past(rx_link_healthy_o) & ~$past(fb, 2)) == '0)
    else $error("health rose off boundary");
  a_health_drop: assert property ((rx_link_healthy_o & ~$past(fl, 2)) == '0)
    else $error("health kept without lock");
  a_cell_mode: assert property (cm_r == $past(cm_r) |-> cell_mode_o == cmx)
    else $error("cell mode mismatch");
endmodule
bind lmc_link_membership_control lmc_asserts #(.NCH(NCH)) chk_u
(
  .clk_i(clk_i), .srst_i(srst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .link_ev_i(link_ev_i), .rx_link_healthy_o(rx_link_healthy_o),
  .tx_enable_o(tx_enable_o), .realign_o(realign_o), .cell_mode_o(cell_mode_o)
);
`default_nettype wire

// ---- testbench/lmc_link_model.sv ----
// Far side model: receive link events and cell availability.
// Assumes its tasks are called from one bench process.
`timescale 1ns/1ps
`default_nettype none
module lmc_link_model
(
  input wire logic clk_i,
  output var lmc_pkg::lmc_link_ev_t [7:0] link_ev_o,
  output logic [7:0] cell_avail_o
);
  initial
  begin
    link_ev_o = '0;
    cell_avail_o = 8'h00;
  end
  // Lock the masked links, then one framing boundary pulse
  task automatic lock(input logic [7:0] m);
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) link_ev_o[i].frame_lock <= m[i];
    cell_avail_o <= m;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) link_ev_o[i].frame_boundary <= m[i];
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) link_ev_o[i].frame_boundary <= 1'b0;
  endtask
  // One sequence number result, correct or in error
  task automatic seq(input int ch, input logic ok);
    @(posedge clk_i);
    if (ok) link_ev_o[ch].seq_ok <= 1'b1;
    else link_ev_o[ch].seq_err <= 1'b1;
    @(posedge clk_i);
    link_ev_o[ch].seq_ok <= 1'b0;
    link_ev_o[ch].seq_err <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Bench for link membership control: APB register tests and link scenarios.
// Assumes the far side model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [19:0] AP = lmc_pkg::ADDR_POLICY;
  localparam logic [19:0] AR = lmc_pkg::ADDR_RESYNC;
  localparam logic [19:0] AM = lmc_pkg::ADDR_CELL_MODE;
  localparam logic [19:0] AC = lmc_pkg::ADDR_ALIGN_CFG;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  lmc_pkg::lmc_link_ev_t [7:0] link_ev;
  logic [7:0] avail, healthy, tx_en, rd_en, realign, cmode, rd, last = 8'h00;
  logic err;
  logic [7:0] rexp [8] = '{8'h00, 8'hf0, 8'hc0, 8'h30, 8'h0f, 8'h0c, 8'h03, 8'hff};
  int failures = 0;
  int checks = 0;
  int npulse = 0;
  int s0;
  always #2.5 clk_i = ~clk_i;
  lmc_link_membership_control dut_u
  (
    .clk_i(clk_i), .srst_i(srst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_ev_i(link_ev), .cell_avail_i(avail),
    .rx_link_healthy_o(healthy), .tx_enable_o(tx_en), .cell_read_en_o(rd_en),
    .realign_o(realign), .cell_mode_o(cmode)
  );
  lmc_link_model link_u (.clk_i(clk_i), .link_ev_o(link_ev), .cell_avail_o(avail));
  always @(posedge clk_i)
  begin
    if (|realign)
    begin
      last <= realign;
      npulse <= npulse + 1;
    end
  end
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input logic [19:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    repeat (4) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    apb(1'b0, AP, 8'h00);
    chk(rd, 8'h00);
    apb(1'b0, AR, 8'h00);
    chk(rd, 8'h00);
    apb(1'b1, AP, 8'hff);
    apb(1'b0, AP, 8'h00);
    chk(rd, 8'hdb);
    apb(1'b1, AR, 8'hff);
    apb(1'b0, AR, 8'h00);
    chk(rd, 8'hfe);
    apb(1'b0, 20'h00ff0, 8'h00);
    chk({7'h00, err}, 8'h01);
    apb(1'b1, AP, 8'h00);
    $display("test registers done");
    apb(1'b1, AC, 8'h5f);
    for (int b = 1; b < 8; b++)
    begin
      apb(1'b1, AR, 8'h00);
      s0 = npulse;
      apb(1'b1, AR, 8'h01 << b);
      settle(AR, 8'h01 << b);
      chk(last, rexp[b] & 8'h5f);
      chk(8'(npulse - s0), 8'h01);
    end
    $display("test resync done");
    link_u.lock(8'hff);
    repeat (4) @(posedge clk_i);
    chk(healthy, 8'hff);
    apb(1'b1, AP, 8'h91);
    for (int i = 0; i < 3; i++) link_u.seq(0, 1'b0);
    for (int i = 0; i < 2; i++) link_u.seq(4, 1'b0);
    repeat (4) @(posedge clk_i);
    chk(healthy, 8'hfe);
    chk(tx_en, 8'hfe);
    apb(1'b1, AP, 8'h99);
    for (int i = 0; i < 5; i++) link_u.seq(0, i != 2);
    repeat (4) @(posedge clk_i);
    chk(healthy, 8'hfe);
    link_u.seq(0, 1'b1);
    repeat (4) @(posedge clk_i);
    chk(healthy, 8'hff);
    apb(1'b1, AP, 8'h10);
    for (int i = 0; i < 3; i++) link_u.seq(1, 1'b0);
    repeat (4) @(posedge clk_i);
    chk(healthy, 8'hfd);
    chk(tx_en, 8'hff);
    $display("test links done");
    settle(AM, 8'h08);
    chk(cmode, 8'h03);
    chk(rd_en, 8'h00);
    settle(AP, 8'h12);
    chk(rd_en, 8'h01);
    settle(AM, 8'h88);
    chk(cmode, 8'hff);
    chk(rd_en, 8'hfd);
    settle(AP, 8'h10);
    chk(rd_en, 8'h00);
    link_u.lock(8'h7f);
    repeat (4) @(posedge clk_i);
    chk(healthy, 8'h7d);
    $display("test cells done");
    end_of_test();
  end
  initial
  begin
    #100000;
    failures++;
    $display("unexpected at %0t: watchdog", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
